// [hdl/amc_axis_mode.sv]
`timescale 1ns/1ps
module amc_axis_mode
  import amc_pkg::*;
#(
  parameter int FILT_CYC_BASE = FILT_T1_CYC
) (
  // Clock and reset
  input  wire logic             I_CLK,
  input  wire logic             I_RST_N,
  // Register port
  input  wire logic [2:0]       I_ADDR,
  input  wire logic [15:0]      I_WDATA,
  input  wire logic             I_WR,
  input  wire logic             I_RD,
  output logic      [15:0]      O_RDATA,
  // Axis input pins, one bit per axis
  input  wire logic [1:0]       I_JOG_PLUS_N,
  input  wire logic [1:0]       I_JOG_MINUS_N,
  input  wire logic [1:0]       I_ALARM,
  input  wire logic [1:0]       I_INPOS,
  // Motion engine side
  input  wire amc_stat_t [1:0]  I_STAT,
  output amc_mode_t [1:0]       O_CFG,
  output amc_ctl_t [1:0]        O_CTL,
  // Output pins, one byte per axis
  output logic [1:0][7:0]       O_OUT_PINS
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [19:0] filt_limit(input logic [2:0] tc);
    if (tc == 3'h0) begin
      filt_limit = 20'(FILT_T0_CYC);
    end else begin
      filt_limit = 20'(FILT_CYC_BASE << (tc - 3'h1));
    end
  endfunction

  function automatic logic [31:0] sel_pos(input amc_stat_t s);
    sel_pos = s.cmp_real_sel ? s.real_pos : s.logic_pos;
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  amc_state_t q;
  amc_state_t d;

  logic       rd_axis;
  assign rd_axis = ~q.sel[0];

  always_comb begin
    logic [3:0]  raw;
    logic [19:0] nxt;
    logic [19:0] lim;
    logic        en;
    logic        jp;
    logic        jm;
    logic        jp_prev;
    logic        jm_prev;
    logic        hit;
    logic        clr;
    logic [31:0] pos;
    logic [7:0]  stat_pins;
    raw       = 4'h0;
    nxt       = 20'h0_0000;
    lim       = 20'h0_0000;
    en        = 1'b0;
    jp        = 1'b0;
    jm        = 1'b0;
    jp_prev   = 1'b0;
    jm_prev   = 1'b0;
    hit       = 1'b0;
    clr       = 1'b0;
    pos       = 32'h0000_0000;
    stat_pins = 8'h00;
    d         = q;
    d.rdata   = 16'h0000;

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    if (I_WR) begin
      case (I_ADDR)
        A_AXSEL: begin
          // A select of no axis keeps the previous choice
          if (I_WDATA[1:0] != 2'h0) begin
            d.sel = I_WDATA[1:0];
          end
        end
        A_MODE: begin
          for (int a = 0; a < AMC_AXES; a++) begin
            if (q.sel[a]) begin
              d.mode[a] = amc_mode_t'(I_WDATA);
            end
          end
        end
        A_GPOUT: begin
          d.gpout = I_WDATA;
        end
        A_SERVO: begin
          for (int a = 0; a < AMC_AXES; a++) begin
            if (q.sel[a]) begin
              d.servo[a] = amc_servo_t'(I_WDATA[2:0]);
            end
          end
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Register reads, data valid only in the following cycle
    // ----------------------------------------------------------------
    if (I_RD) begin
      case (I_ADDR)
        A_AXSEL: d.rdata = {14'h0000, q.sel};
        A_MODE:  d.rdata = q.mode[rd_axis];
        A_GPOUT: d.rdata = q.gpout;
        A_SERVO: d.rdata = {13'h0000, q.servo[rd_axis]};
        A_ERR:   d.rdata = {1'b0, q.alarm[rd_axis], 14'h0000};
        A_PINS:  d.rdata = {q.pins[1], q.pins[0]};
        default: d.rdata = 16'h0000;
      endcase
    end

    // ----------------------------------------------------------------
    // Per-axis logic
    // ----------------------------------------------------------------
    for (int a = 0; a < AMC_AXES; a++) begin
      // Jog pins are stored active high so reset means released
      raw = {I_INPOS[a], I_ALARM[a], ~I_JOG_MINUS_N[a], ~I_JOG_PLUS_N[a]};
      lim = filt_limit(q.mode[a].filter_time_constant);
      for (int k = 0; k < 4; k++) begin
        en = (k < 2) ? q.mode[a].input_filter_enables[FE_JOG]
                     : q.mode[a].input_filter_enables[FE_SERVO];
        nxt = q.cnt[a][k] + 20'h0_0001;
        d.prev[a][k] = q.filt[a][k];
        if (!en || (raw[k] == q.filt[a][k])) begin
          d.filt[a][k] = raw[k];
          d.cnt[a][k]  = 20'h0_0000;
        end else if (nxt >= lim) begin
          // Input held steady for the whole delay: accept it
          d.filt[a][k] = raw[k];
          d.cnt[a][k]  = 20'h0_0000;
        end else begin
          d.cnt[a][k]  = nxt;
        end
      end

      // Alarm: a sticky error bit and a stop level to the engine
      hit = q.servo[a].servo_alarm_enable &
            (q.servo[a].alarm_level ? q.filt[a][2] : ~q.filt[a][2]);
      clr = I_WR && (I_ADDR == A_ERR) && q.sel[a] && I_WDATA[ERR_ALARM];
      // Set wins over a clear in the same cycle
      d.alarm[a] = (q.alarm[a] & ~clr) | hit;

      // External jog inputs
      jp      = q.filt[a][0];
      jm      = q.filt[a][1];
      jp_prev = q.prev[a][0];
      jm_prev = q.prev[a][1];
      d.ctl[a].cont_plus   = 1'b0;
      d.ctl[a].cont_minus  = 1'b0;
      d.ctl[a].fixed_plus  = 1'b0;
      d.ctl[a].fixed_minus = 1'b0;
      case (q.mode[a].ext_drive_mode)
        EXT_CONT: begin
          d.ctl[a].cont_plus  = jp & ~hit;
          d.ctl[a].cont_minus = jm & ~hit;
        end
        EXT_FIXED: begin
          // Stored level rises when the pin falls
          d.ctl[a].fixed_plus  = jp & ~jp_prev & ~hit;
          d.ctl[a].fixed_minus = jm & ~jm_prev & ~hit;
        end
        EXT_PULSER: begin
          // Minus pin low gates the pulser; plus edges give direction
          if (jm) begin
            d.ctl[a].fixed_plus  = ~jp & jp_prev & ~hit;
            d.ctl[a].fixed_minus = jp & ~jp_prev & ~hit;
          end
        end
        default: begin
        end
      endcase
      d.ctl[a].stop     = hit;
      d.ctl[a].inpos_ok = q.servo[a].in_position_level ?
                          q.filt[a][3] : ~q.filt[a][3];

      // Deceleration start and active rate
      d.ctl[a].decel_start = q.mode[a].manual_decel_select ?
                             I_STAT[a].manual_decel_hit :
                             I_STAT[a].auto_decel_hit;
      // Shared rate unless the separate rate is enabled and slowing
      d.ctl[a].rate = (I_STAT[a].decel &&
                       q.mode[a].separate_decel_rate_enable) ?
                      I_STAT[a].decel_rate :
                      I_STAT[a].accel_rate;

      // Output pins
      pos = sel_pos(I_STAT[a]);
      stat_pins[0] = I_STAT[a].jerk_rising;
      stat_pins[1] = I_STAT[a].jerk_falling;
      stat_pins[2] = $signed(pos) >= $signed(I_STAT[a].cmp_plus);
      stat_pins[3] = $signed(pos) < $signed(I_STAT[a].cmp_minus);
      stat_pins[4] = I_STAT[a].pulsing;
      stat_pins[5] = I_STAT[a].driving & I_STAT[a].accel;
      stat_pins[6] = I_STAT[a].driving &
                     I_STAT[a].constant_speed;
      stat_pins[7] = I_STAT[a].driving & I_STAT[a].decel;
      if (q.mode[a].output_pin_source_select) begin
        d.pins[a] = stat_pins;
      end else begin
        d.pins[a] = q.gpout[a*8 +: 8];
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      q       <= '0;
      q.sel   <= SEL_RST;
      q.mode  <= {AMC_AXES{MODE_RST}};
      q.gpout <= GPOUT_RST;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Profile, triangle prevention and ring flags go straight to the engine
  assign O_CFG      = q.mode;
  assign O_CTL      = q.ctl;
  assign O_OUT_PINS = q.pins;
  assign O_RDATA    = q.rdata;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  a_mode_write_lands: assert property (
    (I_WR && (I_ADDR == A_MODE) && q.sel[0] && !q.sel[1])
      |=> (q.mode[0] == $past(I_WDATA)) && $stable(q.mode[1]))
    else $error("mode write missed the selected axis");

  a_decel_rate_pick: assert property (
    (I_STAT[0].decel && q.mode[0].separate_decel_rate_enable)
      |=> (O_CTL[0].rate == $past(I_STAT[0].decel_rate)))
    else $error("separate deceleration rate not used");

  a_shared_rate: assert property (
    !q.mode[0].separate_decel_rate_enable
      |=> (O_CTL[0].rate == $past(I_STAT[0].accel_rate)))
    else $error("shared rate not used");

  a_decel_source: assert property (
    (q.mode[0].manual_decel_select && I_STAT[0].manual_decel_hit)
      |=> O_CTL[0].decel_start)
    else $error("manual deceleration start lost");

  a_gp_pins: assert property (
    !q.mode[0].output_pin_source_select
      |=> (O_OUT_PINS[0] == $past(q.gpout[7:0])))
    else $error("pins do not follow general output");

  a_cmp_plus_pin: assert property (
    (q.mode[0].output_pin_source_select &&
     ($signed(sel_pos(I_STAT[0])) >= $signed(I_STAT[0].cmp_plus)))
      |=> O_OUT_PINS[0][2])
    else $error("plus compare pin low");

  a_drive_pin: assert property (
    (q.mode[0].output_pin_source_select && I_STAT[0].pulsing)
      |=> O_OUT_PINS[0][4])
    else $error("pulse status pin low");

  a_cont_jog: assert property (
    ((q.mode[0].ext_drive_mode == EXT_CONT) && q.filt[0][0] &&
     !d.ctl[0].stop) |=> O_CTL[0].cont_plus)
    else $error("continuous jog not driving");

  a_fixed_once: assert property (
    O_CTL[0].fixed_plus && (q.mode[0].ext_drive_mode == EXT_FIXED)
      |=> !O_CTL[0].fixed_plus)
    else $error("fixed start longer than one cycle");

  a_alarm_sticky: assert property (
    O_CTL[0].stop |-> (q.alarm[0] && q.servo[0].servo_alarm_enable))
    else $error("alarm stop without error bit");

  a_inpos_level: assert property (
    q.servo[0].in_position_level ##1 q.servo[0].in_position_level
      |-> (O_CTL[0].inpos_ok == $past(q.filt[0][3])))
    else $error("in-position level wrong");

  a_read_one_cycle: assert property (
    !I_RD |=> (O_RDATA == 16'h0000))
    else $error("read data outside its cycle");

  a_cmp_minus_pin: assert property (
    (q.mode[0].output_pin_source_select &&
     ($signed(sel_pos(I_STAT[0])) < $signed(I_STAT[0].cmp_minus)))
      |=> O_OUT_PINS[0][3])
    else $error("minus compare pin low");

  a_jerk_pins: assert property (
    q.mode[0].output_pin_source_select
      |=> (O_OUT_PINS[0][1:0] ==
           $past({I_STAT[0].jerk_falling, I_STAT[0].jerk_rising})))
    else $error("jerk status pins wrong");

  a_drive_phase: assert property (
    q.mode[0].output_pin_source_select
      |=> (O_OUT_PINS[0][7:5] ==
           $past({I_STAT[0].decel, I_STAT[0].constant_speed,
                  I_STAT[0].accel} & {3{I_STAT[0].driving}})))
    else $error("drive phase pins wrong");

  a_alarm_stop: assert property (
    (q.servo[0].servo_alarm_enable && !q.servo[0].alarm_level &&
     !q.filt[0][2]) |=> (O_CTL[0].stop && q.alarm[0]))
    else $error("active alarm did not stop the axis");

  a_fixed_edge: assert property (
    ((q.mode[0].ext_drive_mode == EXT_FIXED) && q.filt[0][1] &&
     !q.prev[0][1] && !d.ctl[0].stop) |=> O_CTL[0].fixed_minus)
    else $error("fixed minus start lost");

  a_pulser_minus: assert property (
    ((q.mode[0].ext_drive_mode == EXT_PULSER) && q.filt[0][1] &&
     q.filt[0][0] && !q.prev[0][0] && !d.ctl[0].stop)
      |=> O_CTL[0].fixed_minus)
    else $error("pulser minus start lost");

  a_ext_off: assert property (
    (q.mode[0].ext_drive_mode == EXT_OFF)
      |=> !(O_CTL[0].cont_plus || O_CTL[0].cont_minus ||
            O_CTL[0].fixed_plus || O_CTL[0].fixed_minus))
    else $error("jog output while external drive is off");

  a_filter_pass: assert property (
    !q.mode[0].input_filter_enables[FE_JOG]
      |=> (q.filt[0][0] == $past(~I_JOG_PLUS_N[0])))
    else $error("unfiltered jog input delayed");

  c_pulser_plus: cover property (
    (q.mode[0].ext_drive_mode == EXT_PULSER) ##1 O_CTL[0].fixed_plus);
  c_alarm_stop: cover property (
    q.servo[0].servo_alarm_enable ##[1:20] O_CTL[0].stop);
  c_status_pins: cover property (
    q.mode[1].output_pin_source_select ##1 O_OUT_PINS[1][6]);
  c_both_axes: cover property (
    I_WR && (I_ADDR == A_MODE) && (q.sel == 2'h3));

endmodule

// [hdl/amc_pkg.sv]
package amc_pkg;

  // ------------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------------
  localparam int          AMC_AXES   = 2;
  localparam logic [2:0]  A_AXSEL    = 3'h0;
  localparam logic [2:0]  A_MODE     = 3'h1;
  localparam logic [2:0]  A_GPOUT    = 3'h2;
  localparam logic [2:0]  A_SERVO    = 3'h3;
  localparam logic [2:0]  A_ERR      = 3'h4;
  localparam logic [2:0]  A_PINS     = 3'h5;
  localparam logic [1:0]  SEL_RST    = 2'h1;
  localparam logic [15:0] MODE_RST   = 16'h0000;
  localparam logic [15:0] GPOUT_RST  = 16'h0000;
  localparam int          ERR_ALARM  = 14;
  localparam int          FE_SERVO   = 2;
  localparam int          FE_JOG     = 3;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int FILT_T0_NS    = 2000;
  localparam int FILT_T1_NS    = 256000;
  localparam int FILT_T0_CYC   =
    (FILT_T0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_T1_CYC   =
    (FILT_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    EXT_OFF    = 2'b00,
    EXT_CONT   = 2'b01,
    EXT_FIXED  = 2'b10,
    EXT_PULSER = 2'b11
  } amc_ext_t;

  typedef struct packed {
    logic [2:0] filter_time_constant;
    logic [4:0] input_filter_enables;
    logic       output_pin_source_select;
    logic       ring_counter_enable;
    logic       triangle_prevent_enable;
    amc_ext_t   ext_drive_mode;
    logic       scurve_profile_select;
    logic       separate_decel_rate_enable;
    logic       manual_decel_select;
  } amc_mode_t;

  typedef struct packed {
    logic in_position_level;
    logic alarm_level;
    logic servo_alarm_enable;
  } amc_servo_t;

  typedef struct packed {
    logic        jerk_rising;
    logic        jerk_falling;
    logic        pulsing;
    logic        driving;
    logic        accel;
    logic        constant_speed;
    logic        decel;
    logic        cmp_real_sel;
    logic        auto_decel_hit;
    logic        manual_decel_hit;
    logic [15:0] accel_rate;
    logic [15:0] decel_rate;
    logic [31:0] logic_pos;
    logic [31:0] real_pos;
    logic [31:0] cmp_plus;
    logic [31:0] cmp_minus;
  } amc_stat_t;

  typedef struct packed {
    logic        cont_plus;
    logic        cont_minus;
    logic        fixed_plus;
    logic        fixed_minus;
    logic        stop;
    logic        inpos_ok;
    logic        decel_start;
    logic [15:0] rate;
  } amc_ctl_t;

  typedef struct packed {
    logic [1:0]             sel;
    amc_mode_t [1:0]        mode;
    amc_servo_t [1:0]       servo;
    logic [15:0]            gpout;
    logic [1:0]             alarm;
    logic [15:0]            rdata;
    logic [1:0][3:0][19:0]  cnt;
    logic [1:0][3:0]        filt;
    logic [1:0][3:0]        prev;
    logic [1:0][7:0]        pins;
    amc_ctl_t [1:0]         ctl;
  } amc_state_t;

endpackage

// [testbench/amc_drv_model.sv]
`timescale 1ns/1ps
module amc_drv_model
  import amc_pkg::*;
(
  // Bench controls
  input  wire amc_stat_t [1:0]  i_stat,
  input  wire logic [1:0]       i_alarm_n,
  input  wire logic [1:0]       i_inpos,
  // Device side
  input  wire amc_ctl_t [1:0]   i_ctl,
  output amc_stat_t [1:0]       o_stat,
  output logic [1:0]            o_alarm,
  output logic [1:0]            o_inpos
);
  // ------------------------------------------------------------------
  // Engine and servo drivers
  // ------------------------------------------------------------------
  always_comb begin
    o_stat = i_stat;
    for (int i = 0; i < AMC_AXES; i++) begin
      // A stopped axis emits no pulses while the stop stands
      if (i_ctl[i].stop) begin
        o_stat[i].pulsing = 1'b0;
        o_stat[i].driving = 1'b0;
      end
    end
  end
  // Alarm idles high, as a driver with an open-collector output would
  assign o_alarm = i_alarm_n;
  assign o_inpos = i_inpos;
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import amc_pkg::*;
  logic             clk = 1'b0;
  logic             rst_n = 1'b0;
  logic [2:0]       addr = 3'h0;
  logic [15:0]      wdata = 16'h0000;
  logic             wr_s = 1'b0;
  logic             rd_s = 1'b0;
  logic [15:0]      rdata;
  logic [1:0]       jp_n = 2'h3;
  logic [1:0]       jm_n = 2'h3;
  logic [1:0]       alm_n = 2'h3;
  logic [1:0]       inp = 2'h0;
  logic [1:0]       alm;
  logic [1:0]       inpos;
  amc_stat_t [1:0]  stat = '0;
  amc_stat_t [1:0]  stat_m;
  amc_mode_t [1:0]  cfg;
  amc_ctl_t [1:0]   ctl;
  logic [1:0][7:0]  pins;
  int               failures = 0;
  int               checks_done = 0;
  int               seed = 11;
  logic [1:0]       sel_m = 2'h1;
  logic [15:0]      gp_m = 16'h0000;
  logic [15:0]      mode_m [2] = '{16'h0000, 16'h0000};
  logic [15:0]      err_m [2] = '{16'h0000, 16'h0000};

  amc_axis_mode #(.FILT_CYC_BASE(4)) u_amc_axis_mode (
    .I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .I_JOG_PLUS_N(jp_n),
    .I_JOG_MINUS_N(jm_n), .I_ALARM(alm), .I_INPOS(inpos),
    .I_STAT(stat_m), .O_CFG(cfg), .O_CTL(ctl), .O_OUT_PINS(pins));
  amc_drv_model u_amc_drv_model (
    .i_stat(stat), .i_alarm_n(alm_n), .i_inpos(inp), .i_ctl(ctl),
    .o_stat(stat_m), .o_alarm(alm), .o_inpos(inpos));

  initial begin
    forever #10 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // Reference model and bus tasks
  // ------------------------------------------------------------------
  function automatic logic [7:0] pexp(input int i);
    amc_stat_t   s;
    logic [31:0] p;
    s = stat[i];
    p = s.cmp_real_sel ? s.real_pos : s.logic_pos;
    if (!mode_m[i][7])
      return gp_m[8*i +: 8];
    return {s.decel & s.driving, s.constant_speed & s.driving,
            s.accel & s.driving, s.pulsing,
            $signed(p) < $signed(s.cmp_minus),
            $signed(p) >= $signed(s.cmp_plus),
            s.jerk_falling, s.jerk_rising};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic settle();
    @(posedge clk);
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    if (a == A_GPOUT)
      gp_m = d;
    if (a == A_AXSEL && d[1:0] != 2'h0)
      sel_m = d[1:0];
    for (int i = 0; i < 2; i++) begin
      if (a == A_MODE && sel_m[i])
        mode_m[i] = d;
      if (a == A_ERR && sel_m[i])
        err_m[i][ERR_ALARM] = err_m[i][ERR_ALARM] & ~d[ERR_ALARM];
    end
  endtask

  task automatic rd_chk(input logic [2:0] a);
    logic [15:0] e;
    int          x;
    x = sel_m[0] ? 0 : 1;
    case (a)
      A_MODE:  e = mode_m[x];
      A_GPOUT: e = gp_m;
      A_ERR:   e = err_m[x];
      A_PINS:  e = {pexp(1), pexp(0)};
      default: e = 16'h0000;
    endcase
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  task automatic jog(input logic p, input logic m, input logic [3:0] e);
    @(posedge clk);
    jp_n[0] <= p;
    jm_n[0] <= m;
    settle();
    chk({ctl[0].cont_plus, ctl[0].cont_minus,
         ctl[0].fixed_plus, ctl[0].fixed_minus}, e);
  endtask

  task automatic close_out();
    if (failures == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out();
  end

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    logic [191:0] rv;
    logic [15:0]  r;
    amc_stat_t    s;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 1; a < 8; a++)
      rd_chk(a[2:0]);
    for (int n = 0; n < 9; n++) begin
      r = 16'($random(seed));
      wr(A_AXSEL, 16'(1 + n % 3));
      wr(A_MODE, r);
      wr(A_AXSEL, 16'h0000);
      wr(A_GPOUT, 16'($random(seed)));
      @(posedge clk);
      for (int i = 0; i < 2; i++) begin
        rv = {$random(seed), $random(seed), $random(seed),
              $random(seed), $random(seed), $random(seed)};
        stat[i] <= rv[$bits(amc_stat_t)-1:0];
      end
      settle();
      for (int i = 0; i < 2; i++) begin
        s = stat[i];
        chk(pins[i], pexp(i));
        chk(cfg[i], mode_m[i]);
        r = mode_m[i][0] ? s.manual_decel_hit : s.auto_decel_hit;
        chk(ctl[i].decel_start, r[0]);
        r = (mode_m[i][1] && s.decel) ? s.decel_rate : s.accel_rate;
        chk(ctl[i].rate, r);
      end
      rd_chk(A_MODE);
      rd_chk(A_PINS);
    end
    // Jog roles on axis X, filters bypassed
    wr(A_AXSEL, 16'h0001);
    wr(A_MODE, 16'h0000);
    jog(1'b0, 1'b0, 4'b0000);
    jog(1'b1, 1'b1, 4'b0000);
    wr(A_MODE, 16'h0008);
    jog(1'b0, 1'b1, 4'b1000);
    jog(1'b1, 1'b0, 4'b0100);
    jog(1'b1, 1'b1, 4'b0000);
    wr(A_MODE, 16'h0012);
    jog(1'b0, 1'b1, 4'b0010);
    jog(1'b1, 1'b0, 4'b0001);
    jog(1'b1, 1'b1, 4'b0000);
    wr(A_MODE, 16'h0018);
    jog(1'b1, 1'b0, 4'b0000);
    jog(1'b0, 1'b0, 4'b0001);
    jog(1'b1, 1'b0, 4'b0010);
    jog(1'b0, 1'b1, 4'b0000);
    jog(1'b1, 1'b1, 4'b0000);
    // Jog filter on, delay code 1: a press must hold four cycles
    wr(A_MODE, 16'h2808);
    jog(1'b0, 1'b1, 4'b0000);
    repeat (2) @(posedge clk);
    #1;
    chk(ctl[0].cont_plus, 1'b0);
    @(posedge clk);
    #1;
    chk(ctl[0].cont_plus, 1'b1);
    jog(1'b1, 1'b1, 4'b1000);
    wr(A_MODE, 16'h0000);
    // Servo alarm enabled, then disabled
    for (int en = 1; en >= 0; en--) begin
      wr(A_SERVO, 16'(en));
      @(posedge clk);
      alm_n[0] <= 1'b0;
      settle();
      chk(ctl[0].stop, en[0]);
      err_m[0][ERR_ALARM] = en[0];
      rd_chk(A_ERR);
      @(posedge clk);
      alm_n[0] <= 1'b1;
      settle();
      chk(ctl[0].stop, 1'b0);
      wr(A_ERR, 16'h4000);
      rd_chk(A_ERR);
    end
    // In-position input active high, then active low
    wr(A_SERVO, 16'h0004);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      inp[0] <= v[0];
      settle();
      chk(ctl[0].inpos_ok, v[0]);
    end
    wr(A_SERVO, 16'h0000);
    settle();
    chk(ctl[0].inpos_ok, 1'b0);
    close_out();
  end
endmodule
